// file: common/tvp_pkg.sv
// package for the timer value and test page register slice
`default_nettype none

package tvp_pkg;

	// ------------------------------------------------------------
	// bus and address geometry
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int COUNT_W = 16;
	localparam int PORT_W = 7;
	localparam int TBUS_W = 8;
	localparam int CLKSRC_W = 3;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_PRELOAD_LOW = 6'h2d;
	localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 6'h2e;
	localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 6'h2f;
	localparam logic [ADDR_W-1:0] OFS_BANK_SEL = 6'h30;
	localparam logic [ADDR_W-1:0] OFS_TEST_FIRST = 6'h31;
	localparam logic [ADDR_W-1:0] OFS_TEST_SECOND = 6'h32;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int BANK_OVR_BIT = 7;
	localparam int BANK_NUM_HI = 1;
	localparam int BANK_NUM_LO = 0;
	localparam int BANK_ADDR_HI = 5;
	localparam int BANK_ADDR_LO = 4;
	localparam int SMC_SRC_HI = 5;
	localparam int SMC_SRC_LO = 4;
	localparam int SMC_D1_BIT = 3;
	localparam int PBIT_HI = 2;
	localparam int PBIT_LO = 0;
	localparam int REORDER_BIT = 7;
	localparam int PRBS9_BIT = 6;
	localparam int PRBS15_BIT = 5;
	localparam int PBUS_HI = 4;
	localparam int PBUS_LO = 0;
	localparam logic [DATA_W-1:0] RST_PRELOAD_LOW = 8'h00;
	localparam logic [DATA_W-1:0] RST_BANK_SEL = 8'h00;
	localparam logic [DATA_W-1:0] RST_TEST_FIRST = 8'h00;
	localparam logic [DATA_W-1:0] RST_TEST_SECOND = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

	// ------------------------------------------------------------
	// pseudo-random generators (x^9+x^5+1, x^15+x^14+1)
	// ------------------------------------------------------------
	localparam int P9_W = 9;
	localparam int P9_TAP = 4;
	localparam int P15_W = 15;
	localparam int P15_TAP = 13;
	localparam logic [P9_W-1:0] P9_SEED = 9'h1ff;
	localparam logic [P15_W-1:0] P15_SEED = 15'h7fff;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TVP_SRC_GROUND = 2'b00,
		TVP_SRC_OSC = 2'b01,
		TVP_SRC_UART = 2'b10,
		TVP_SRC_FIELD = 2'b11
	} tvp_clk_src_t;

	typedef enum logic [1:0] {
		TVP_PRBS_IDLE = 2'b00,
		TVP_PRBS_ARMED = 2'b01,
		TVP_PRBS_SEND = 2'b10
	} tvp_prbs_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tvp_bus_req_t;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] rdata;
	} tvp_bus_rsp_t;

endpackage

`default_nettype wire

// file: hdl/tvp_pin_sync.sv
// three-stage input synchroniser with agreement filter for foreign clock levels
`default_nettype none

module tvp_pin_sync
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [tvp_pkg::CLKSRC_W-1:0] pin_in,
	output logic [tvp_pkg::CLKSRC_W-1:0] pin_out
);
	import tvp_pkg::*;

	logic [CLKSRC_W-1:0] stage_a;
	logic [CLKSRC_W-1:0] stage_b;
	logic [CLKSRC_W-1:0] stage_c;

	// ------------------------------------------------------------
	// shift chain; stage_a is only read by stage_b
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			stage_a <= '0;
			stage_b <= '0;
			stage_c <= '0;
		end
		else
		begin
			stage_a <= pin_in;
			stage_b <= stage_a;
			stage_c <= stage_b;
		end
	end

	// ------------------------------------------------------------
	// a bit changes only once the last two stages agree
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			pin_out <= '0;
		else
			for (int i = 0; i < CLKSRC_W; i++)
				if (stage_b[i] == stage_c[i])
					pin_out[i] <= stage_c[i];
	end

endmodule // tvp_pin_sync

`default_nettype wire

// file: hdl/tvp_regs.sv
// timer preload/count registers, bank selector and test configuration registers
//
// The address-and-strobe port was left to the implementer.
`default_nettype none

// Notes on behaviour
// - each timer start loads the 16-bit preload value built from both preload bytes into the count.
// - preload writes while the timer runs leave the running count alone until the next start.
// - the live count reads as two read-only bytes, upper at one address and lower at the next.
// - the live count has no defined value after reset and only means something after a start.
// - with the override bit set, the bank number supplies address bits five and four.
// - with the override bit clear, the whole address comes from the address latch.
// - the bank number in bits one and zero counts only while the override bit is set.
// - bank selector bits six to two are reserved, read zero, and the register resets to zero.
// - bits five and four pick the secure module clock: ground, oscillator, uart or field clock.
// - bit three drives the secure module clock onto data line one unless the parallel host is in use.
// - bits two to zero pick which test bus bit goes to the signal output pin.
// - the second test register holds reorder, two sequence enables and a five-bit bus choice.
// - a sequence enable arms its pseudo-random sequence, sent only after the transmit command.
// - with reorder set the test bus reaches the parallel port as D4 D3 D2 D6 D5 D0 D1.
module tvp_regs
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire tvp_pkg::tvp_bus_req_t bus_req,
	output tvp_pkg::tvp_bus_rsp_t bus_rsp,
	output logic [tvp_pkg::ADDR_W-1:0] effective_addr,
	input wire logic [tvp_pkg::DATA_W-1:0] timer_preload_upper,
	input wire logic timer_start,
	input wire logic timer_stop,
	input wire logic timer_tick,
	output logic timer_running,
	input wire logic [tvp_pkg::CLKSRC_W-1:0] clk_source_pins,
	input wire logic parallel_host_active,
	output logic secure_module_clk,
	output logic data_line_one_out,
	output logic data_line_one_oe,
	input wire logic [tvp_pkg::TBUS_W-1:0] test_bus,
	output logic signal_output_pin,
	output logic [tvp_pkg::PORT_W-1:0] probe_port,
	output logic [tvp_pkg::PBUS_HI:0] probe_bus_choice,
	input wire logic tx_send_cmd,
	input wire logic tx_bit_en,
	output logic prbs_active,
	output logic prbs_bit
);
	import tvp_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// address seen by the decoder, after the bank override
	function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] latch,
		input logic ovr, input logic [1:0] bank);
		logic [ADDR_W-1:0] res;
		res = latch;
		if (ovr)
			res[BANK_ADDR_HI:BANK_ADDR_LO] = bank;
		return res;
	endfunction

	// alternate mapping of test bus bits 6..0 onto port lines
	function automatic logic [PORT_W-1:0] reorder(input logic [PORT_W-1:0] tb);
		logic [PORT_W-1:0] p;
		p = '0;
		p[4] = tb[6];
		p[3] = tb[5];
		p[2] = tb[4];
		p[6] = tb[3];
		p[5] = tb[2];
		p[0] = tb[1];
		p[1] = tb[0];
		return p;
	endfunction

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] timer_preload_lower;
	logic bank_override_enable;
	logic [1:0] bank_number;
	tvp_clk_src_t secure_module_clk_source;
	logic secure_clk_to_data_line_one;
	logic [PBIT_HI:0] probe_bit_choice;
	logic probe_bus_reorder;
	logic prbs9_enable;
	logic prbs15_enable;
	logic [COUNT_W-1:0] live_count;
	logic [COUNT_W-1:0] timer_preload_value;
	logic [ADDR_W-1:0] dec_addr;
	logic wr_hit;
	logic [CLKSRC_W-1:0] clk_source_sync;
	tvp_prbs_state_t prbs_state;
	tvp_prbs_state_t next_prbs_state;
	logic [P9_W-1:0] lfsr9;
	logic [P15_W-1:0] lfsr15;
	logic use_p9;
	logic [DATA_W-1:0] next_rdata;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign dec_addr = map_addr(bus_req.addr, bank_override_enable, bank_number);
	assign effective_addr = dec_addr;
	assign wr_hit = bus_req.wr;
	assign timer_preload_value = {timer_preload_upper, timer_preload_lower};

	// preload low byte
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			timer_preload_lower <= RST_PRELOAD_LOW;
		else if (wr_hit && dec_addr == OFS_PRELOAD_LOW)
			timer_preload_lower <= bus_req.wdata;
	end

	// bank selector: only the override bit and bank number are stored
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			bank_override_enable <= RST_BANK_SEL[BANK_OVR_BIT];
			bank_number <= RST_BANK_SEL[BANK_NUM_HI:BANK_NUM_LO];
		end
		else if (wr_hit && dec_addr == OFS_BANK_SEL)
		begin
			bank_override_enable <= bus_req.wdata[BANK_OVR_BIT];
			bank_number <= bus_req.wdata[BANK_NUM_HI:BANK_NUM_LO];
		end
	end

	// first test register; bits 7:6 have no storage
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			secure_module_clk_source <= tvp_clk_src_t'(RST_TEST_FIRST[SMC_SRC_HI:SMC_SRC_LO]);
			secure_clk_to_data_line_one <= RST_TEST_FIRST[SMC_D1_BIT];
			probe_bit_choice <= RST_TEST_FIRST[PBIT_HI:PBIT_LO];
		end
		else if (wr_hit && dec_addr == OFS_TEST_FIRST)
		begin
			secure_module_clk_source <= tvp_clk_src_t'(bus_req.wdata[SMC_SRC_HI:SMC_SRC_LO]);
			secure_clk_to_data_line_one <= bus_req.wdata[SMC_D1_BIT];
			probe_bit_choice <= bus_req.wdata[PBIT_HI:PBIT_LO];
		end
	end

	// second test register
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			probe_bus_reorder <= RST_TEST_SECOND[REORDER_BIT];
			prbs9_enable <= RST_TEST_SECOND[PRBS9_BIT];
			prbs15_enable <= RST_TEST_SECOND[PRBS15_BIT];
			probe_bus_choice <= RST_TEST_SECOND[PBUS_HI:PBUS_LO];
		end
		else if (wr_hit && dec_addr == OFS_TEST_SECOND)
		begin
			probe_bus_reorder <= bus_req.wdata[REORDER_BIT];
			prbs9_enable <= bus_req.wdata[PRBS9_BIT];
			prbs15_enable <= bus_req.wdata[PRBS15_BIT];
			probe_bus_choice <= bus_req.wdata[PBUS_HI:PBUS_LO];
		end
	end

	// ------------------------------------------------------------
	// timer count
	// ------------------------------------------------------------

	// run flag; start wins over stop in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			timer_running <= 1'b0;
		else if (timer_start)
			timer_running <= 1'b1;
		else if (timer_stop || (timer_tick && live_count == '0))
			timer_running <= 1'b0;
	end

	// the count has no reset on purpose: it is undefined until the first start
	// bus writes never reach it, so a stray write to its bytes is harmless
	always_ff @(posedge sys_clk)
	begin
		if (timer_start)
			live_count <= timer_preload_value;
		else if (timer_running && timer_tick && live_count != '0)
			live_count <= live_count - COUNT_W'(1);
	end

	// ------------------------------------------------------------
	// secure module clock
	// ------------------------------------------------------------

	// the sources come from foreign clocks; a 125 MHz sample is only a level copy
	tvp_pin_sync u_clk_sync
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(clk_source_pins),
		.pin_out(clk_source_sync)
	);

	// source selection
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			secure_module_clk <= 1'b0;
		else
		begin
			case (secure_module_clk_source)
				TVP_SRC_GROUND: secure_module_clk <= 1'b0;
				TVP_SRC_OSC: secure_module_clk <= clk_source_sync[0];
				TVP_SRC_UART: secure_module_clk <= clk_source_sync[1];
				TVP_SRC_FIELD: secure_module_clk <= clk_source_sync[2];
				default: secure_module_clk <= 1'b0;
			endcase
		end
	end

	// data line one only carries the clock while the parallel host is idle,
	// otherwise the host owns that pin and a second driver would fight it
	assign data_line_one_oe = secure_clk_to_data_line_one && !parallel_host_active;
	assign data_line_one_out = secure_module_clk;

	// ------------------------------------------------------------
	// test bus routing
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			signal_output_pin <= 1'b0;
			probe_port <= '0;
		end
		else
		begin
			signal_output_pin <= test_bus[probe_bit_choice];
			if (probe_bus_reorder)
				probe_port <= reorder(test_bus[PORT_W-1:0]);
			else
				probe_port <= test_bus[PORT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// pseudo-random sequence
	// ------------------------------------------------------------

	// the nine-bit sequence wins when both enables are set
	assign use_p9 = prbs9_enable;

	// idle -> armed on enable, armed -> send on the transmit command
	always_comb
	begin
		next_prbs_state = prbs_state;
		case (prbs_state)
			TVP_PRBS_IDLE:
				if (prbs9_enable || prbs15_enable)
					next_prbs_state = TVP_PRBS_ARMED;
			TVP_PRBS_ARMED:
				if (!(prbs9_enable || prbs15_enable))
					next_prbs_state = TVP_PRBS_IDLE;
				else if (tx_send_cmd)
					next_prbs_state = TVP_PRBS_SEND;
			TVP_PRBS_SEND:
				if (!(prbs9_enable || prbs15_enable))
					next_prbs_state = TVP_PRBS_IDLE;
			default:
				next_prbs_state = TVP_PRBS_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			prbs_state <= TVP_PRBS_IDLE;
		else
			prbs_state <= next_prbs_state;
	end

	// generators reseed whenever not sending so each run starts the same
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst || prbs_state != TVP_PRBS_SEND)
		begin
			lfsr9 <= P9_SEED;
			lfsr15 <= P15_SEED;
		end
		else if (tx_bit_en)
		begin
			lfsr9 <= {lfsr9[P9_W-2:0], lfsr9[P9_W-1] ^ lfsr9[P9_TAP]};
			lfsr15 <= {lfsr15[P15_W-2:0], lfsr15[P15_W-1] ^ lfsr15[P15_TAP]};
		end
	end

	// sequence output
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			prbs_active <= 1'b0;
			prbs_bit <= 1'b0;
		end
		else
		begin
			prbs_active <= (prbs_state == TVP_PRBS_SEND);
			prbs_bit <= use_p9 ? lfsr9[P9_W-1] : lfsr15[P15_W-1];
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------

	// unmapped and reserved positions read as zero
	always_comb
	begin
		next_rdata = READ_ZERO;
		case (dec_addr)
			OFS_PRELOAD_LOW: next_rdata = timer_preload_lower;
			OFS_COUNT_HIGH: next_rdata = live_count[COUNT_W-1:DATA_W];
			OFS_COUNT_LOW: next_rdata = live_count[DATA_W-1:0];
			OFS_BANK_SEL:
			begin
				next_rdata[BANK_OVR_BIT] = bank_override_enable;
				next_rdata[BANK_NUM_HI:BANK_NUM_LO] = bank_number;
			end
			OFS_TEST_FIRST:
			begin
				next_rdata[SMC_SRC_HI:SMC_SRC_LO] = secure_module_clk_source;
				next_rdata[SMC_D1_BIT] = secure_clk_to_data_line_one;
				next_rdata[PBIT_HI:PBIT_LO] = probe_bit_choice;
			end
			OFS_TEST_SECOND:
			begin
				next_rdata[REORDER_BIT] = probe_bus_reorder;
				next_rdata[PRBS9_BIT] = prbs9_enable;
				next_rdata[PRBS15_BIT] = prbs15_enable;
				next_rdata[PBUS_HI:PBUS_LO] = probe_bus_choice;
			end
			default: next_rdata = READ_ZERO;
		endcase
	end

	// read data stands for exactly the cycle after the strobe
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			bus_rsp.valid <= 1'b0;
			bus_rsp.rdata <= READ_ZERO;
		end
		else
		begin
			bus_rsp.valid <= bus_req.rd;
			bus_rsp.rdata <= bus_req.rd ? next_rdata : READ_ZERO;
		end
	end

endmodule // tvp_regs

`default_nettype wire

// file: tb/tvp_regs_checker.sv
// port-level assertions for the timer value and test page register slice
`default_nettype none

module tvp_regs_checker
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire tvp_pkg::tvp_bus_req_t bus_req,
	input wire tvp_pkg::tvp_bus_rsp_t bus_rsp,
	input wire logic [tvp_pkg::ADDR_W-1:0] effective_addr,
	input wire logic timer_start,
	input wire logic timer_running,
	input wire logic parallel_host_active,
	input wire logic secure_module_clk,
	input wire logic data_line_one_out,
	input wire logic data_line_one_oe,
	input wire logic [tvp_pkg::PBUS_HI:0] probe_bus_choice,
	input wire logic tx_send_cmd,
	input wire logic prbs_active
);
	timeunit 1ns;
	timeprecision 100ps;
	import tvp_pkg::*;

	// --------------------
	// one clock domain, so one default clocking
	// --------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// read request and timer start as named steps
	sequence rd_taken;
		bus_req.rd;
	endsequence
	sequence start_taken;
		timer_start ##1 timer_running;
	endsequence

	// --------------------
	// assertions
	// --------------------
	rd_answer_a: assert property (rd_taken |=> bus_rsp.valid)
		else $error("read without answer");
	rsp_quiet_a: assert property (!bus_req.rd |=> !bus_rsp.valid && bus_rsp.rdata == 8'h00)
		else $error("answer without read");
	start_run_a: assert property (timer_start |-> start_taken)
		else $error("start did not run timer");
	bank_rsvd_a: assert property (rd_taken ##0 effective_addr == OFS_BANK_SEL
		|=> bus_rsp.rdata[6:2] == 5'h00) else $error("bank reserved bits set");
	first_rsvd_a: assert property (rd_taken ##0 effective_addr == OFS_TEST_FIRST
		|=> bus_rsp.rdata[7:6] == 2'h0) else $error("test reserved bits set");
	bus_choice_a: assert property (bus_req.wr && effective_addr == OFS_TEST_SECOND
		|=> {3'h0, probe_bus_choice} == ($past(bus_req.wdata) & 8'h1f))
		else $error("bus choice not stored");
	low_addr_a: assert property (effective_addr[3:0] == bus_req.addr[3:0])
		else $error("low address bits altered");
	host_gate_a: assert property (parallel_host_active |-> !data_line_one_oe)
		else $error("data line driven during host use");
	d1_follow_a: assert property (data_line_one_oe |-> data_line_one_out == secure_module_clk)
		else $error("data line not secure clock");
	// the driver may only switch on after a first test register write or when the host lets go
	d1_enable_a: assert property ($rose(data_line_one_oe) |->
		($past(bus_req.wr) && $past(effective_addr) == OFS_TEST_FIRST)
		|| $fell(parallel_host_active)) else $error("data line driver switched on unasked");
	prbs_cmd_a: assert property ($rose(prbs_active) |-> $past(tx_send_cmd, 2))
		else $error("sequence sent without command");
endmodule // tvp_regs_checker

bind tvp_regs tvp_regs_checker u_tvp_regs_checker (.sys_clk, .sys_rst, .bus_req, .bus_rsp,
	.effective_addr, .timer_start, .timer_running, .parallel_host_active, .secure_module_clk,
	.data_line_one_out, .data_line_one_oe, .probe_bus_choice, .tx_send_cmd, .prbs_active);

`default_nettype wire

// file: tb/tvp_regs_test.sv
// self-checking testbench for the timer value and test page register slice
`default_nettype none

module tvp_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	import tvp_pkg::*;

	// --------------------
	// stimulus and observed signals
	// --------------------
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	tvp_bus_req_t bus_req = '0;
	tvp_bus_rsp_t bus_rsp;
	logic [ADDR_W-1:0] effective_addr;
	logic [7:0] timer_preload_upper = 8'h00;
	logic timer_start = 1'b0;
	logic timer_stop = 1'b0;
	logic timer_tick = 1'b0;
	logic timer_running;
	logic [2:0] clk_source_pins = 3'h0;
	logic parallel_host_active = 1'b0;
	logic secure_module_clk, data_line_one_out, data_line_one_oe;
	logic [7:0] test_bus = 8'h00;
	logic signal_output_pin;
	logic [6:0] probe_port;
	logic [4:0] probe_bus_choice;
	logic tx_send_cmd = 1'b0;
	logic tx_bit_en = 1'b0;
	logic prbs_active, prbs_bit;
	int miscompares = 0;
	int checked = 0;

	tvp_regs u_tvp_regs (.sys_clk, .sys_rst, .bus_req, .bus_rsp, .effective_addr,
		.timer_preload_upper, .timer_start, .timer_stop, .timer_tick, .timer_running,
		.clk_source_pins, .parallel_host_active, .secure_module_clk, .data_line_one_out,
		.data_line_one_oe, .test_bus, .signal_output_pin, .probe_port, .probe_bus_choice,
		.tx_send_cmd, .tx_bit_en, .prbs_active, .prbs_bit);

	// 8 ns period
	always #4 sys_clk = ~sys_clk;

	// --------------------
	// shared tasks
	// --------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe; the slave never stalls
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req.wr <= 1'b1;
		bus_req.addr <= a;
		bus_req.wdata <= d;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		bus_req.rd <= 1'b1;
		bus_req.addr <= a;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk({7'h00, bus_rsp.valid}, 8'h01);
		chk(bus_rsp.rdata, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic start_timer;
		@(posedge sys_clk);
		timer_start <= 1'b1;
		@(posedge sys_clk);
		timer_start <= 1'b0;
	endtask

	task automatic report_and_stop;
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// --------------------
	// scenarios
	// --------------------
	task automatic t_fields;
		rd(OFS_PRELOAD_LOW, 8'h00);
		rd(OFS_TEST_FIRST, 8'h00);
		rd(OFS_TEST_SECOND, 8'h00);
		wr(OFS_BANK_SEL, 8'hff);
		rd(OFS_BANK_SEL, 8'h83);
		wr(OFS_BANK_SEL, 8'h00);
		rd(OFS_BANK_SEL, 8'h00);
		wr(OFS_TEST_FIRST, 8'hc0);
		rd(OFS_TEST_FIRST, 8'h00);
		wr(OFS_TEST_SECOND, 8'h9f);
		rd(OFS_TEST_SECOND, 8'h9f);
		chk({3'h0, probe_bus_choice}, 8'h1f);
	endtask

	// override on: low address bits plus bank number; off: latch alone
	task automatic t_bank;
		wr(OFS_BANK_SEL, 8'h83);
		wr(6'h01, 8'h15);
		rd(6'h01, 8'h15);
		rd(6'h00, 8'h83);
		wr(6'h00, 8'h03);
		rd(6'h01, 8'h00);
		rd(OFS_TEST_FIRST, 8'h15);
	endtask

	task automatic t_timer;
		@(posedge sys_clk);
		timer_preload_upper <= 8'h12;
		wr(OFS_PRELOAD_LOW, 8'h34);
		start_timer;
		rd(OFS_COUNT_HIGH, 8'h12);
		rd(OFS_COUNT_LOW, 8'h34);
		@(posedge sys_clk);
		timer_tick <= 1'b1;
		repeat (2) @(posedge sys_clk);
		timer_tick <= 1'b0;
		wr(OFS_PRELOAD_LOW, 8'h99);
		wr(OFS_COUNT_LOW, 8'h00);
		rd(OFS_COUNT_LOW, 8'h32);
		chk({7'h00, timer_running}, 8'h01);
		start_timer;
		rd(OFS_COUNT_LOW, 8'h99);
		@(posedge sys_clk);
		timer_stop <= 1'b1;
		@(posedge sys_clk);
		timer_stop <= 1'b0;
		#1;
		chk({7'h00, timer_running}, 8'h00);
	endtask

	// bit choice to the output pin, then every clock source code
	task automatic t_test1;
		for (int i = 0; i < 8; i++)
		begin
			wr(OFS_TEST_FIRST, 8'(i));
			test_bus <= 8'h01 << i;
			cyc(2);
			chk({7'h00, signal_output_pin}, 8'h01);
			@(posedge sys_clk);
			test_bus <= ~(8'h01 << i);
			cyc(2);
			chk({7'h00, signal_output_pin}, 8'h00);
		end
		for (int s = 0; s < 4; s++)
		begin
			wr(OFS_TEST_FIRST, {2'b00, 2'(s), 4'h8});
			clk_source_pins <= (s == 0) ? 3'h7 : 3'(1 << (s - 1));
			cyc(8);
			chk({7'h00, secure_module_clk}, {7'h00, s != 0});
			chk({7'h00, data_line_one_out}, {7'h00, s != 0});
			chk({7'h00, data_line_one_oe}, 8'h01);
			@(posedge sys_clk);
			clk_source_pins <= ~clk_source_pins;
			cyc(8);
			chk({7'h00, secure_module_clk}, 8'h00);
		end
		@(posedge sys_clk);
		parallel_host_active <= 1'b1;
		cyc(2);
		chk({7'h00, data_line_one_oe}, 8'h00);
		@(posedge sys_clk);
		parallel_host_active <= 1'b0;
	endtask

	task automatic t_reorder;
		int dst[7] = '{1, 0, 5, 6, 2, 3, 4};
		wr(OFS_TEST_SECOND, 8'h00);
		test_bus <= 8'h5a;
		cyc(2);
		chk({1'b0, probe_port}, 8'h5a);
		wr(OFS_TEST_SECOND, 8'h80);
		for (int k = 0; k < 7; k++)
		begin
			@(posedge sys_clk);
			test_bus <= 8'h01 << k;
			cyc(2);
			chk({1'b0, probe_port}, 8'h01 << dst[k]);
		end
	endtask

	// both sequence lengths: armed by the enable, sent only on command
	task automatic t_prbs;
		logic [7:0] en[2] = '{8'h40, 8'h20};
		for (int m = 0; m < 2; m++)
		begin
			wr(OFS_TEST_SECOND, en[m]);
			cyc(6);
			chk({7'h00, prbs_active}, 8'h00);
			@(posedge sys_clk);
			tx_send_cmd <= 1'b1;
			@(posedge sys_clk);
			tx_send_cmd <= 1'b0;
			#1;
			chk({7'h00, prbs_active}, 8'h00);
			cyc(1);
			chk({7'h00, prbs_active}, 8'h01);
			chk({7'h00, prbs_bit}, 8'h01);
			// one full register length of shifts brings the first feedback bit (1 xor 1) to the top
			@(posedge sys_clk);
			tx_bit_en <= 1'b1;
			repeat ((m == 0) ? P9_W : P15_W) @(posedge sys_clk);
			tx_bit_en <= 1'b0;
			cyc(1);
			chk({7'h00, prbs_bit}, 8'h00);
			wr(OFS_TEST_SECOND, 8'h00);
			cyc(3);
			chk({7'h00, prbs_active}, 8'h00);
		end
	endtask

	// --------------------
	// main sequence and watchdog
	// --------------------
	initial
	begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_fields;
		t_bank;
		t_timer;
		t_test1;
		t_reorder;
		t_prbs;
		report_and_stop;
	end

	// the whole run needs about three hundred cycles; this cuts a hang
	initial
	begin
		#100000;
		miscompares++;
		report_and_stop;
	end
endmodule // tvp_regs_test

`default_nettype wire
